/* dmac_chan.v */
// one dma channel: registers, request latch, address and count logic
`timescale 1ns/10ps
`include "dmac_consts.vh"

module dmac_chan #(
  parameter AW = 11,
  parameter CW = 11,
  parameter QW = 7
) (
  input  wire          sys_clk,
  input  wire          rst_n,
  input  wire          wr_en,
  input  wire [2:0]    wr_sel,
  input  wire [15:0]   wr_data,
  input  wire [2:0]    rd_sel,
  output reg  [15:0]   rd_val,
  input  wire [127:0]  req_vec,
  input  wire          force_req,
  input  wire [AW-1:0] ind_offs,
  input  wire          grant_done,
  output wire          req,
  output wire [15:0]   ctrl,
  output reg  [AW-1:0] ram_addr,
  output wire [15:0]   per_addr,
  output wire          irq
);

  reg [15:0]   ctrl_r;
  reg [15:0]   sta_r;
  reg [15:0]   stb_r;
  reg [15:0]   pad_r;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] xfer_r;
  reg [QW-1:0] sel_r;
  reg [AW-1:0] offs_r;
  reg          ping_r;
  reg          pend_r;
  reg          irq_r;

  // the twenty irq numbers that may drive a channel
  function irq_ok;
    input [QW-1:0] n;
    begin
      case (n)
        7'd0, 7'd1, 7'd2, 7'd5, 7'd6, 7'd7, 7'd8, 7'd10, 7'd11, 7'd12,
        7'd13, 7'd21, 7'd30, 7'd31, 7'd33, 7'd34, 7'd55, 7'd60, 7'd70, 7'd71: irq_ok = 1'b1;
        default: irq_ok = 1'b0;
      endcase
    end
  endfunction

  wire          en      = ctrl_r[`DMAC_CTRL_EN];
  wire          hit     = en & req_vec[sel_r] & irq_ok(sel_r);
  wire [1:0]    am      = ctrl_r[`DMAC_CTRL_AM_HI:`DMAC_CTRL_AM_LO];
  wire [1:0]    md      = ctrl_r[`DMAC_CTRL_MD_HI:`DMAC_CTRL_MD_LO];
  wire [AW-1:0] base    = ping_r ? stb_r[AW-1:0] : sta_r[AW-1:0];
  wire [AW-1:0] step    = ctrl_r[`DMAC_CTRL_SIZE] ? {{(AW-1){1'b0}}, 1'b1} : {{(AW-2){1'b0}}, 2'b10};
  wire [CW-1:0] xfer_n  = xfer_r + {{(CW-1){1'b0}}, 1'b1};
  wire [CW:0]   cnt_p1  = {1'b0, cnt_r} + {{CW{1'b0}}, 1'b1};
  wire [CW-1:0] half_pt = cnt_p1[CW:1];
  wire          last    = (xfer_r == cnt_r);

  assign req      = pend_r & en;
  assign ctrl     = ctrl_r;
  assign per_addr = pad_r;
  assign irq      = irq_r;

  always @* begin
    case (am)
      `DMAC_AM_POSTINC: ram_addr = base + offs_r;
      `DMAC_AM_PERIND:  ram_addr = base + ind_offs;
      default:          ram_addr = base;
    endcase
  end

  always @* begin
    case (rd_sel)
      `DMAC_REG_CTRL: rd_val = ctrl_r;
      `DMAC_REG_STA:  rd_val = sta_r;
      `DMAC_REG_STB:  rd_val = stb_r;
      `DMAC_REG_PAD:  rd_val = pad_r;
      `DMAC_REG_CNT:  rd_val = {{(16-CW){1'b0}}, cnt_r};
      `DMAC_REG_SEL:  rd_val = {{(16-QW){1'b0}}, sel_r};
      `DMAC_REG_STAT: rd_val = {pend_r, ping_r, {(14-CW){1'b0}}, xfer_r};
      default:        rd_val = 16'h0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `DMAC_CTRL_RST;
      sta_r  <= 16'h0000;
      stb_r  <= 16'h0000;
      pad_r  <= 16'h0000;
      cnt_r  <= {CW{1'b0}};
      xfer_r <= {CW{1'b0}};
      sel_r  <= {QW{1'b0}};
      offs_r <= {AW{1'b0}};
      ping_r <= 1'b0;
      pend_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      if (grant_done)
        pend_r <= 1'b0;
      if (hit | (force_req & en))
        pend_r <= 1'b1;
      if (grant_done) begin
        xfer_r <= xfer_n;
        offs_r <= offs_r + step;
        if (ctrl_r[`DMAC_CTRL_HALF] && xfer_n == half_pt)
          irq_r <= 1'b1;
        if (last) begin
          xfer_r <= {CW{1'b0}};
          offs_r <= {AW{1'b0}};
          if (!ctrl_r[`DMAC_CTRL_HALF])
            irq_r <= 1'b1;
          if (md[1])
            ping_r <= ~ping_r;
          if (md[0] && !(md[1] && !ping_r))
            ctrl_r[`DMAC_CTRL_EN] <= 1'b0;
        end
      end
      if (wr_en) begin
        case (wr_sel)
          `DMAC_REG_CTRL: begin
            ctrl_r <= wr_data & `DMAC_CTRL_MASK;
            xfer_r <= {CW{1'b0}};
            offs_r <= {AW{1'b0}};
            ping_r <= 1'b0;
          end
          `DMAC_REG_STA: sta_r <= wr_data;
          `DMAC_REG_STB: stb_r <= wr_data;
          `DMAC_REG_PAD: pad_r <= wr_data;
          `DMAC_REG_CNT: cnt_r <= wr_data[CW-1:0];
          `DMAC_REG_SEL: sel_r <= wr_data[QW-1:0];
          default: ;
        endcase
      end
    end
  end

endmodule // dmac_chan

/* dmac_consts.vh */
// constants for the eight-channel dma controller
`ifndef DMAC_CONSTS_VH
`define DMAC_CONSTS_VH

// per-channel register select, word index = {channel, select}
`define DMAC_REG_CTRL    3'h0
`define DMAC_REG_STA     3'h1
`define DMAC_REG_STB     3'h2
`define DMAC_REG_PAD     3'h3
`define DMAC_REG_CNT     3'h4
`define DMAC_REG_SEL     3'h5
`define DMAC_REG_STAT    3'h6

// global registers, word index
`define DMAC_GLB_IE      8'h40
`define DMAC_GLB_FORCE   8'h41

// control register fields
`define DMAC_CTRL_EN     15
`define DMAC_CTRL_SIZE   14
`define DMAC_CTRL_DIR    13
`define DMAC_CTRL_HALF   12
`define DMAC_CTRL_NULL_WRITE_SELECT  11
`define DMAC_CTRL_AM_HI  5
`define DMAC_CTRL_AM_LO  4
`define DMAC_CTRL_MD_HI  1
`define DMAC_CTRL_MD_LO  0
`define DMAC_CTRL_MASK   16'hf833
`define DMAC_CTRL_RST    16'h0000

// addressing modes
`define DMAC_AM_POSTINC  2'h0
`define DMAC_AM_NOINC    2'h1
`define DMAC_AM_PERIND   2'h2

// interrupt enable register 4
`define DMAC_IE_CH7      5
`define DMAC_IE_CH6      4
`define DMAC_IE_MASK     16'h0030
`define DMAC_IE_RST      16'h0000

`endif

/* dmac_per_model.sv */
// peripheral register model answering dma reads
`timescale 1ns/10ps
module dmac_per_model (
  input  wire logic        sys_clk,
  input  wire logic        per_rd,
  input  wire logic [15:0] per_addr,
  output logic      [15:0] per_rdata
);
  initial per_rdata = 16'h0000;
  // data only valid the cycle after the strobe
  always @(posedge sys_clk)
    if (per_rd) per_rdata <= per_addr ^ 16'h5a5a;
    else per_rdata <= ~per_rdata;
endmodule // dmac_per_model

/* dmac_props.sv */
// port assertions for the dma controller
`timescale 1ns/10ps
module dmac_props #(parameter NCH = 8) (
  input wire logic           sys_clk,
  input wire logic           rst_n,
  input wire logic           reg_rd,
  input wire logic [15:0]    reg_rdata,
  input wire logic           per_rd,
  input wire logic           per_wr,
  input wire logic [NCH-1:0] dma_irq,
  input wire logic           dma_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_busy_run;
    dma_busy[*3] ##1 !dma_busy;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !dma_busy && !per_rd && !per_wr && dma_irq == '0) else $error("output active in reset");
  a_rd_pulse: assert property (per_rd |=> !per_rd) else $error("read strobe too long");
  a_wr_pulse: assert property (per_wr |=> !per_wr) else $error("write strobe too long");
  a_dir_excl: assert property (!(per_rd && per_wr)) else $error("read and write together");
  a_strobe_busy: assert property ((per_rd || per_wr) |-> dma_busy) else $error("strobe while idle");
  a_busy_len: assert property ($rose(dma_busy) |-> s_busy_run) else $error("busy length wrong");
  a_rd_spacing: assert property (per_rd |=> !per_rd[*3]) else $error("reads too close");
  a_irq_pulse: assert property ((dma_irq & $past(dma_irq)) == '0) else $error("irq not a pulse");
  a_rdata_hold: assert property ($past(rst_n) && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
endmodule // dmac_props

bind dmac_top dmac_props #(.NCH(NCH)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .per_rd(per_rd), .per_wr(per_wr), .dma_irq(dma_irq), .dma_busy(dma_busy));

/* dmac_tb.sv */
// self-checking testbench for the dma controller
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} dmac_row_t;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [15:0]  reg_wdata = 16'h0000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [127:0] per_req = '0;
  logic [9:0]   ram_a = 10'h000;
  logic [15:0]  ram_d = 16'h0000;
  logic         ram_w = 1'b0;
  logic         ram_r = 1'b0;
  logic [10:0]  ind_offs = 11'h000;
  wire  [15:0]  reg_rdata, per_addr, per_wdata, per_rdata, ram_q;
  wire          per_wr, per_rd, dma_busy;
  wire  [7:0]   dma_irq;
  int           miscompares = 0;
  int           comparisons = 0;
  int           n_rd = 0;
  int           irq_n [8];
  logic [15:0]  rd_addr, wr_addr, wr_data;
  dmac_row_t    rows [5];

  always #10 sys_clk = ~sys_clk;

  dmac_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .per_req(per_req),
    .per_ind_offs(ind_offs), .per_addr(per_addr), .per_wdata(per_wdata), .per_wr(per_wr),
    .per_rd(per_rd), .per_rdata(per_rdata), .cpu_ram_addr(ram_a), .cpu_ram_wdata(ram_d),
    .cpu_ram_wr(ram_w), .cpu_ram_rd(ram_r), .cpu_ram_rdata(ram_q), .dma_irq(dma_irq),
    .dma_busy(dma_busy));
  dmac_per_model i_per (.sys_clk(sys_clk), .per_rd(per_rd), .per_addr(per_addr), .per_rdata(per_rdata));

  always @(posedge sys_clk) begin
    if (per_rd) begin
      n_rd <= n_rd + 1;
      rd_addr <= per_addr;
    end
    if (per_wr) begin
      wr_addr <= per_addr;
      wr_data <= per_wdata;
    end
    for (int k = 0; k < 8; k++)
      if (dma_irq[k] === 1'b1) irq_n[k] <= irq_n[k] + 1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ram(input logic w, input logic [9:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    ram_w <= w;
    ram_r <= !w;
    ram_a <= a;
    ram_d <= d;
    @(posedge sys_clk);
    ram_w <= 1'b0;
    ram_r <= 1'b0;
    #1 q = ram_q;
  endtask
  task automatic pulse(input int n);
    @(posedge sys_clk);
    per_req <= 128'h1 << n;
    @(posedge sys_clk);
    per_req <= '0;
  endtask
  task automatic close_out;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    logic [15:0] v;
    int i0;
    rows[0] = '{8'h00, 16'hffff, 16'hf833};
    rows[1] = '{8'h40, 16'hffff, 16'h0030};
    rows[2] = '{8'h7f, 16'hffff, 16'h0000};
    rows[3] = '{8'h0d, 16'h00ff, 16'h007f};
    rows[4] = '{8'h3c, 16'hffff, 16'h07ff};
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h40, v);
    chk(v, 16'h0000);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, v);
      chk(v, rows[k].e);
    end
    rd(8'h08, v);
    chk(v, 16'h0000);
    // peripheral to ram, one word, one-shot
    wr(8'h00, 16'h0000);
    wr(8'h01, 16'h0000);
    wr(8'h03, 16'h0240);
    wr(8'h04, 16'h0000);
    wr(8'h05, 16'h000b);
    wr(8'h00, 16'h8001);
    pulse(11);
    for (int c = 0; c < 40 && irq_n[0] == 0; c++)
      @(posedge sys_clk);
    chk(rd_addr, 16'h0240);
    chk(16'(irq_n[0]), 16'h0001);
    ram(1'b0, 10'h000, 16'h0000, v);
    chk(v, 16'h581a);
    rd(8'h00, v);
    chk(v, 16'h0001);
    // disabled channel and unlisted source are ignored
    wr(8'h0d, 16'h0003);
    wr(8'h08, 16'h8000);
    i0 = n_rd;
    pulse(11);
    pulse(3);
    repeat (20) @(posedge sys_clk);
    chk(16'(n_rd - i0), 16'h0000);
    // ram to peripheral on channel 7, forced, irq gated
    ram(1'b1, 10'h005, 16'hbeef, v);
    wr(8'h39, 16'h000a);
    wr(8'h3b, 16'h0300);
    wr(8'h3c, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      wr(8'h40, p ? 16'h0020 : 16'h0000);
      i0 = irq_n[7];
      wr(8'h38, 16'ha001);
      wr(8'h41, 16'h0080);
      repeat (12) @(posedge sys_clk);
      chk(wr_data, 16'hbeef);
      chk(wr_addr, 16'h0300);
      chk(16'(irq_n[7] - i0), 16'(p));
    end
    // continuous ping-pong, half interrupt, null write on channel 2
    wr(8'h11, 16'h0020);
    wr(8'h12, 16'h0040);
    wr(8'h13, 16'h0100);
    wr(8'h14, 16'h0001);
    wr(8'h15, 16'h000d);
    wr(8'h10, 16'h9802);
    i0 = irq_n[2];
    for (int t = 0; t < 4; t++) begin
      pulse(13);
      repeat (7) @(posedge sys_clk);
      chk(16'(irq_n[2] - i0), 16'((t + 2) / 2));
      chk(wr_data, 16'h0000);
    end
    chk(wr_addr, 16'h0100);
    ram(1'b0, 10'h010, 16'h0000, v);
    chk(v, 16'h5b5a);
    ram(1'b0, 10'h011, 16'h0000, v);
    chk(v, 16'h5b5a);
    ram(1'b0, 10'h020, 16'h0000, v);
    chk(v, 16'h5b5a);
    ram(1'b0, 10'h021, 16'h0000, v);
    chk(v, 16'h5b5a);
    rd(8'h10, v);
    chk(v, 16'h9802);
    rd(8'h16, v);
    chk(v, 16'h0000);
    // peripheral indirect byte transfer on channel 3, one-shot
    ram(1'b1, 10'h043, 16'h1234, v);
    wr(8'h19, 16'h0080);
    ind_offs <= 11'h006;
    wr(8'h1b, 16'h0200);
    wr(8'h1d, 16'h001e);
    wr(8'h18, 16'hc021);
    pulse(30);
    repeat (7) @(posedge sys_clk);
    ram(1'b0, 10'h043, 16'h0000, v);
    chk(v, 16'h125a);
    rd(8'h18, v);
    chk(v, 16'h4021);
    // reset with channel 2 still enabled and no transfer in flight returns registers and outputs to zero
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({15'h0000, dma_busy}, 16'h0000);
    rd(8'h10, v);
    chk(v, 16'h0000);
    rd(8'h40, v);
    chk(v, 16'h0000);
    close_out();
  end
endmodule // testbench

/* dmac_top.v */
// eight-channel dma controller with dual-ported dma ram
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "dmac_consts.vh"

module dmac_top #(
  parameter NCH   = 8,
  parameter AW    = 11,
  parameter CW    = 11,
  parameter DEPTH = 1024
) (
  input  wire          sys_clk,
  input  wire          rst_n,
  input  wire [7:0]    reg_addr,
  input  wire [15:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [15:0]   reg_rdata,
  input  wire [127:0]  per_req,
  input  wire [AW-1:0] per_ind_offs,
  output reg  [15:0]   per_addr,
  output reg  [15:0]   per_wdata,
  output reg           per_wr,
  output reg           per_rd,
  input  wire [15:0]   per_rdata,
  input  wire [AW-2:0] cpu_ram_addr,
  input  wire [15:0]   cpu_ram_wdata,
  input  wire          cpu_ram_wr,
  input  wire          cpu_ram_rd,
  output reg  [15:0]   cpu_ram_rdata,
  output reg  [NCH-1:0] dma_irq,
  output reg           dma_busy
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_ISSUE = 4'b0010;
  localparam [3:0] ST_MOVE  = 4'b0100;
  localparam [3:0] ST_ACK   = 4'b1000;

  reg  [15:0]       ram_r [0:DEPTH-1];
  reg  [3:0]        st_r;
  reg  [2:0]        cur_r;
  reg               dir_r;
  reg               size_r;
  reg               null_write_select_r;
  reg  [AW-1:0]     ram_a_r;
  reg  [15:0]       data_r;
  reg  [15:0]       ie_r;
  reg  [NCH-1:0]    force_r;

  wire [NCH-1:0]    req_w;
  wire [NCH-1:0]    irq_w;
  wire [NCH*16-1:0] ctrl_w;
  wire [NCH*16-1:0] pad_w;
  wire [NCH*16-1:0] rdv_w;
  wire [NCH*AW-1:0] ram_a_w;
  wire [NCH-1:0]    done_w;

  // lowest numbered requesting channel wins
  function [2:0] pick;
    input [7:0] v;
    integer k;
    begin
      pick = 3'h0;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          pick = k[2:0];
    end
  endfunction

  wire [2:0]    win      = pick(req_w);
  wire [15:0]   win_ctrl = ctrl_w[win*16 +: 16];
  wire [AW-1:0] win_a    = ram_a_w[win*AW +: AW];
  wire [15:0]   win_word = ram_r[win_a[AW-1:1]];
  wire          glb_sel  = (reg_addr[7:6] == 2'b01);
  wire [2:0]    rch      = reg_addr[5:3];

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      assign done_w[g] = st_r[3] & (cur_r == g);
      dmac_chan #(
        .AW (AW),
        .CW (CW),
        .QW (7)
      ) u_chan (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .wr_en      (reg_wr & (reg_addr[7:6] == 2'b00) & (rch == g)),
        .wr_sel     (reg_addr[2:0]),
        .wr_data    (reg_wdata),
        .rd_sel     (reg_addr[2:0]),
        .rd_val     (rdv_w[g*16 +: 16]),
        .req_vec    (per_req),
        .force_req  (force_r[g]),
        .ind_offs   (per_ind_offs),
        .grant_done (done_w[g]),
        .req        (req_w[g]),
        .ctrl       (ctrl_w[g*16 +: 16]),
        .ram_addr   (ram_a_w[g*AW +: AW]),
        .per_addr   (pad_w[g*16 +: 16]),
        .irq        (irq_w[g])
      );
    end
  endgenerate

  // register read port, data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      ie_r      <= `DMAC_IE_RST;
      force_r   <= {NCH{1'b0}};
    end else begin
      force_r <= {NCH{1'b0}};
      if (reg_wr && reg_addr == `DMAC_GLB_IE)
        ie_r <= reg_wdata & `DMAC_IE_MASK;
      if (reg_wr && reg_addr == `DMAC_GLB_FORCE)
        force_r <= reg_wdata[NCH-1:0];
      if (reg_rd) begin
        if (reg_addr[7:6] == 2'b00)
          reg_rdata <= rdv_w[rch*16 +: 16];
        else if (reg_addr == `DMAC_GLB_IE)
          reg_rdata <= ie_r;
        else if (glb_sel && reg_addr[5:0] == 6'h02)
          reg_rdata <= {8'h00, req_w};
        else
          reg_rdata <= 16'h0000;
      end
    end
  end

  // channel interrupts, 7 and 6 gated by their enables
  always @(posedge sys_clk) begin
    if (!rst_n)
      dma_irq <= {NCH{1'b0}};
    else begin
      dma_irq <= irq_w;
      dma_irq[7] <= irq_w[7] & ie_r[`DMAC_IE_CH7];
      dma_irq[6] <= irq_w[6] & ie_r[`DMAC_IE_CH6];
    end
  end

  // cpu port of the dual-ported ram, never waits
  always @(posedge sys_clk) begin
    if (!rst_n)
      cpu_ram_rdata <= 16'h0000;
    else if (cpu_ram_rd)
      cpu_ram_rdata <= ram_r[cpu_ram_addr];
  end

  wire        dma_ram_we = st_r[2] & ~dir_r;
  wire        collide    = cpu_ram_wr & (cpu_ram_addr == ram_a_r[AW-1:1]);
  wire [15:0] old_word   = ram_r[ram_a_r[AW-1:1]];
  wire [15:0] byte_word  = ram_a_r[0] ? {per_rdata[7:0], old_word[7:0]}
                                      : {old_word[15:8], per_rdata[7:0]};

  // ram storage; cpu write takes a colliding location
  always @(posedge sys_clk) begin
    if (cpu_ram_wr)
      ram_r[cpu_ram_addr] <= cpu_ram_wdata;
    if (dma_ram_we && !collide)
      ram_r[ram_a_r[AW-1:1]] <= size_r ? byte_word : per_rdata;
  end

  // transfer engine on the dedicated dma bus
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r      <= ST_IDLE;
      cur_r     <= 3'h0;
      dir_r     <= 1'b0;
      size_r    <= 1'b0;
      null_write_select_r   <= 1'b0;
      ram_a_r   <= {AW{1'b0}};
      data_r    <= 16'h0000;
      per_addr  <= 16'h0000;
      per_wdata <= 16'h0000;
      per_wr    <= 1'b0;
      per_rd    <= 1'b0;
      dma_busy  <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          per_wr <= 1'b0;
          if (|req_w) begin
            cur_r    <= win;
            dir_r    <= win_ctrl[`DMAC_CTRL_DIR];
            size_r   <= win_ctrl[`DMAC_CTRL_SIZE];
            null_write_select_r  <= win_ctrl[`DMAC_CTRL_NULL_WRITE_SELECT] & ~win_ctrl[`DMAC_CTRL_DIR];
            ram_a_r  <= win_a;
            per_addr <= pad_w[win*16 +: 16];
            dma_busy <= 1'b1;
            if (win_ctrl[`DMAC_CTRL_DIR]) begin
              if (win_ctrl[`DMAC_CTRL_SIZE])
                data_r <= {8'h00, win_a[0] ? win_word[15:8] : win_word[7:0]};
              else
                data_r <= win_word;
            end else
              per_rd <= 1'b1;
            st_r <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          per_rd <= 1'b0;
          st_r   <= ST_MOVE;
        end
        ST_MOVE: begin
          if (dir_r) begin
            per_wr    <= 1'b1;
            per_wdata <= data_r;
          end else if (null_write_select_r) begin
            per_wr    <= 1'b1;
            per_wdata <= 16'h0000;
          end
          st_r <= ST_ACK;
        end
        ST_ACK: begin
          per_wr   <= 1'b0;
          dma_busy <= 1'b0;
          st_r     <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // dmac_top
